// [design/i2c_channel_sequence_control.sv]
// Per-channel START/STOP sequence control with AXI4-Lite registers
// What this block does
// - Clear halt_request when bus STOP is seen
// - Each channel control register has own address
// - halt_after_run stops at sequence end, idles
// - Errors still reported until final STOP
// - Clear halt_after_run when bus STOP is seen
// - Flags reset zero; writing zero does nothing
// - begin_flag starts only on free bus for open-drain channel 0; push-pull channels skip the check
// - Busy bus at start: interrupt low, fault
// - Clear begin_flag: sequence done, count one
// - Clear begin_flag: loop done, count above one
// - Clear begin_flag: halt_after_run sequence done
// - Clear begin_flag: halt_request byte done
// - Refuse begin_flag while channel_on is zero
// - halt_request stops after current byte
// - NACK last read byte before halt STOP
// - Single-byte halt drops buffered transactions
// - Halt writes ignored while begin_flag zero
// - halt_request wins over halt_after_run
`default_nettype none
module i2c_channel_sequence_control #(
	parameter int N = i2c_seq_pkg::NCH
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [N-1:0] scl_in,
	input wire logic [N-1:0] sda_in,
	input wire logic [N-1:0] byte_done,
	input wire logic [N-1:0] seq_done,
	input wire logic [N-1:0] loop_done,
	input wire logic [N-1:0] reading,
	input wire logic [N-1:0] xfer_err,
	output logic [N-1:0] send_start,
	output logic [N-1:0] send_stop,
	output logic [N-1:0] flush_seq,
	output logic [N-1:0] nack_last,
	output logic int_n
);
	// Address decode: {hit, channel, kind}
	function automatic logic [4:0] reg_decode(input logic [7:0] a);
		logic [4:0] r;
		logic [7:0] base;
		r = 5'h00;
		for (int c = 0; c < N; c++) begin
			base = 8'(c * i2c_seq_pkg::CH_STRIDE);
			if (a == i2c_seq_pkg::CTRL_OFS + base) r = {1'b1, 2'(c), i2c_seq_pkg::KIND_CTRL};
			if (a == i2c_seq_pkg::CFG_OFS + base) r = {1'b1, 2'(c), i2c_seq_pkg::KIND_CFG};
			if (a == i2c_seq_pkg::COND_OFS + base) r = {1'b1, 2'(c), i2c_seq_pkg::KIND_COND};
		end
		return r;
	endfunction : reg_decode

	// Bus write path holding registers
	logic aw_full_ff; // Write address held
	logic [7:0] aw_addr_ff;
	logic w_full_ff; // Write data held
	logic [31:0] w_data_ff;
	logic [3:0] w_strb_ff;
	logic bvalid_ff;
	logic [1:0] bresp_ff;
	logic rvalid_ff;
	logic [1:0] rresp_ff;
	logic [31:0] rdata_ff;
	logic wr_go; // Both halves present, perform write
	logic [4:0] wdec; // Write decode
	logic [4:0] rdec; // Read decode

	// Channel state
	i2c_seq_pkg::ch_state_t state_ff [N];
	logic [N-1:0] halt_run_ff; // halt_after_run
	logic [N-1:0] begin_ff; // begin_flag
	logic [N-1:0] halt_req_ff; // halt_request
	logic [N-1:0] chon_ff; // channel_on
	logic [i2c_seq_pkg::CNT_W-1:0] cnt_ff [N]; // repeat_count
	logic [N-1:0] dfault_ff; // data_line_fault
	logic [N-1:0] cfault_ff; // Clock line fault
	logic [N-1:0] xfault_ff; // Transfer fault
	logic [N-1:0] busy_ff; // Bus seen busy between START and STOP
	logic [N-1:0] send_start_ff;
	logic [N-1:0] send_stop_ff;
	logic [N-1:0] flush_ff;
	logic [N-1:0] nack_ff;
	logic int_n_ff;

	// Per-channel combinational events
	logic [N-1:0] scl_s, sda_s, start_det, stop_det;
	logic [N-1:0] wr_ctrl, wr_cfg, wr_cond; // Write hits per channel
	logic [N-1:0] begin_acc; // Accepted host begin request
	logic [N-1:0] start_ok, start_fail;
	logic [N-1:0] halt_byte, halt_seq, end_one, end_loop, finish;
	logic [N-1:0] set_halt_run, set_halt_req;

	// Serial lines cross into aclk here
	link_sync #(.W(N)) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.scl_s(scl_s),
		.sda_s(sda_s),
		.start_det(start_det),
		.stop_det(stop_det)
	);

	// Bus handshakes: one write and one read in flight
	assign s_axi_awready = !aw_full_ff && !bvalid_ff;
	assign s_axi_wready = !w_full_ff && !bvalid_ff;
	assign s_axi_arready = !rvalid_ff;
	assign wr_go = aw_full_ff && w_full_ff && !bvalid_ff;
	assign wdec = reg_decode(aw_addr_ff);
	assign rdec = reg_decode(s_axi_araddr);

	// Address and data may arrive in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_ff <= 1'b0;
			aw_addr_ff <= 8'h00;
			w_full_ff <= 1'b0;
			w_data_ff <= 32'h00000000;
			w_strb_ff <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_ff <= 1'b1;
				aw_addr_ff <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_full_ff <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_ff <= 1'b1;
				w_data_ff <= s_axi_wdata;
				w_strb_ff <= s_axi_wstrb;
			end else if (wr_go) begin
				w_full_ff <= 1'b0;
			end
		end
	end

	// Write response; unmapped address answers SLVERR
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_ff <= 1'b0;
			bresp_ff <= i2c_seq_pkg::RESP_OKAY;
		end else if (wr_go) begin
			bvalid_ff <= 1'b1;
			bresp_ff <= wdec[4] ? i2c_seq_pkg::RESP_OKAY : i2c_seq_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	// Read data captured one cycle after address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rresp_ff <= i2c_seq_pkg::RESP_OKAY;
			rdata_ff <= 32'h00000000;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_ff <= 1'b1;
			rresp_ff <= rdec[4] ? i2c_seq_pkg::RESP_OKAY : i2c_seq_pkg::RESP_SLVERR;
			rdata_ff <= 32'h00000000;
			if (rdec[4]) begin
				unique case (rdec[1:0])
					i2c_seq_pkg::KIND_CTRL: begin
						rdata_ff[i2c_seq_pkg::HALT_RUN_BIT] <= halt_run_ff[rdec[3:2]];
						rdata_ff[i2c_seq_pkg::BEGIN_BIT] <= begin_ff[rdec[3:2]];
						rdata_ff[i2c_seq_pkg::HALT_REQ_BIT] <= halt_req_ff[rdec[3:2]];
					end
					i2c_seq_pkg::KIND_CFG: begin
						rdata_ff[i2c_seq_pkg::CNT_W-1:0] <= cnt_ff[rdec[3:2]];
						rdata_ff[i2c_seq_pkg::CHON_BIT] <= chon_ff[rdec[3:2]];
					end
					default: begin
						// Condition word shows live state
						rdata_ff[i2c_seq_pkg::DATA_FAULT_BIT] <= dfault_ff[rdec[3:2]];
						rdata_ff[i2c_seq_pkg::CLK_FAULT_BIT] <= cfault_ff[rdec[3:2]];
						rdata_ff[i2c_seq_pkg::XFER_FAULT_BIT] <= xfault_ff[rdec[3:2]];
						rdata_ff[i2c_seq_pkg::ACTIVE_BIT] <= state_ff[rdec[3:2]] != i2c_seq_pkg::CH_IDLE;
					end
				endcase
			end
		end else if (s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	// Channel events; priority order fixes the stop reason
	always_comb begin
		for (int c = 0; c < N; c++) begin
			wr_ctrl[c] = wr_go && wdec[4] && wdec[3:2] == 2'(c) && wdec[1:0] == i2c_seq_pkg::KIND_CTRL && w_strb_ff[0];
			wr_cfg[c] = wr_go && wdec[4] && wdec[3:2] == 2'(c) && wdec[1:0] == i2c_seq_pkg::KIND_CFG;
			wr_cond[c] = wr_go && wdec[4] && wdec[3:2] == 2'(c) && wdec[1:0] == i2c_seq_pkg::KIND_COND && w_strb_ff[0];
			// Zero writes do nothing; begin needs channel_on
			begin_acc[c] = wr_ctrl[c] && w_data_ff[i2c_seq_pkg::BEGIN_BIT] && chon_ff[c]
				&& !begin_ff[c] && state_ff[c] == i2c_seq_pkg::CH_IDLE;
			// Push-pull channels skip the busy-bus check
			start_ok[c] = begin_acc[c] && (i2c_seq_pkg::PP_CHANNELS[c]
				|| (!busy_ff[c] && scl_s[c] && sda_s[c]));
			start_fail[c] = begin_acc[c] && !start_ok[c];
			// Halt requests count only while begin_flag is set
			set_halt_run[c] = wr_ctrl[c] && w_data_ff[i2c_seq_pkg::HALT_RUN_BIT] && begin_ff[c];
			set_halt_req[c] = wr_ctrl[c] && w_data_ff[i2c_seq_pkg::HALT_REQ_BIT] && begin_ff[c];
			halt_byte[c] = state_ff[c] == i2c_seq_pkg::CH_RUN && halt_req_ff[c] && byte_done[c];
			halt_seq[c] = state_ff[c] == i2c_seq_pkg::CH_RUN && !halt_byte[c] && !halt_req_ff[c]
				&& halt_run_ff[c] && seq_done[c];
			end_one[c] = state_ff[c] == i2c_seq_pkg::CH_RUN && !halt_req_ff[c] && !halt_run_ff[c]
				&& seq_done[c] && cnt_ff[c] == 8'h01;
			end_loop[c] = state_ff[c] == i2c_seq_pkg::CH_RUN && !halt_req_ff[c] && !halt_run_ff[c]
				&& loop_done[c] && cnt_ff[c] > 8'h01;
			finish[c] = halt_byte[c] || halt_seq[c] || end_one[c] || end_loop[c];
		end
	end

	// Control flags; hardware clears win over writes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			begin_ff <= '0;
			halt_run_ff <= '0;
			halt_req_ff <= '0;
		end else begin
			for (int c = 0; c < N; c++) begin
				if (finish[c] || start_fail[c]) begin
					begin_ff[c] <= 1'b0;
				end else if (start_ok[c]) begin
					begin_ff[c] <= 1'b1;
				end
				if (stop_det[c]) begin
					halt_run_ff[c] <= 1'b0;
					halt_req_ff[c] <= 1'b0;
				end else begin
					if (set_halt_run[c]) halt_run_ff[c] <= 1'b1;
					if (set_halt_req[c]) halt_req_ff[c] <= 1'b1;
				end
			end
		end
	end

	// Configuration: repeat_count and channel_on
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			chon_ff <= '0;
			for (int c = 0; c < N; c++) cnt_ff[c] <= i2c_seq_pkg::CNT_RST;
		end else begin
			for (int c = 0; c < N; c++) begin
				if (wr_cfg[c] && w_strb_ff[0]) cnt_ff[c] <= w_data_ff[i2c_seq_pkg::CNT_W-1:0];
				if (wr_cfg[c] && w_strb_ff[1]) chon_ff[c] <= w_data_ff[i2c_seq_pkg::CHON_BIT];
			end
		end
	end

	// Sequencing state per channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int c = 0; c < N; c++) state_ff[c] <= i2c_seq_pkg::CH_IDLE;
		end else begin
			for (int c = 0; c < N; c++) begin
				unique case (state_ff[c])
					i2c_seq_pkg::CH_IDLE: if (start_ok[c]) state_ff[c] <= i2c_seq_pkg::CH_RUN;
					i2c_seq_pkg::CH_RUN: if (finish[c]) state_ff[c] <= i2c_seq_pkg::CH_STOPPING;
					// Idle only once the STOP is really on the wire
					i2c_seq_pkg::CH_STOPPING: if (stop_det[c]) state_ff[c] <= i2c_seq_pkg::CH_IDLE;
				endcase
			end
		end
	end

	// Bus occupancy seen from START/STOP on the lines
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy_ff <= '0;
		end else begin
			busy_ff <= (busy_ff | start_det) & ~stop_det;
		end
	end

	// Faults; a new event beats a software clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dfault_ff <= '0;
			cfault_ff <= '0;
			xfault_ff <= '0;
		end else begin
			for (int c = 0; c < N; c++) begin
				// Data low blames data line, else clock line
				if (start_fail[c] && !sda_s[c]) dfault_ff[c] <= 1'b1;
				else if (wr_cond[c] && w_data_ff[i2c_seq_pkg::DATA_FAULT_BIT]) dfault_ff[c] <= 1'b0;
				if (start_fail[c] && sda_s[c]) cfault_ff[c] <= 1'b1;
				else if (wr_cond[c] && w_data_ff[i2c_seq_pkg::CLK_FAULT_BIT]) cfault_ff[c] <= 1'b0;
				// Errors keep landing through the stopping phase
				if (xfer_err[c] && state_ff[c] != i2c_seq_pkg::CH_IDLE) xfault_ff[c] <= 1'b1;
				else if (wr_cond[c] && w_data_ff[i2c_seq_pkg::XFER_FAULT_BIT]) xfault_ff[c] <= 1'b0;
			end
		end
	end

	// Registered commands toward the byte engine
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			send_start_ff <= '0;
			send_stop_ff <= '0;
			flush_ff <= '0;
			nack_ff <= '0;
			int_n_ff <= 1'b1;
		end else begin
			send_start_ff <= start_ok;
			send_stop_ff <= finish;
			flush_ff <= halt_byte | halt_seq;
			for (int c = 0; c < N; c++) begin
				nack_ff[c] <= state_ff[c] == i2c_seq_pkg::CH_RUN && halt_req_ff[c] && reading[c];
			end
			int_n_ff <= !(|(dfault_ff | cfault_ff | xfault_ff));
		end
	end

	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rresp = rresp_ff;
	assign s_axi_rdata = rdata_ff;
	assign send_start = send_start_ff;
	assign send_stop = send_stop_ff;
	assign flush_seq = flush_ff;
	assign nack_last = nack_ff;
	assign int_n = int_n_ff;

	// Checks on channel zero, the open-drain channel
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	begin_needs_on_a: assert property ($rose(begin_ff[0]) |-> $past(chon_ff[0]))
		else $error("begin set with channel off");
	halt_ignored_a: assert property ($rose(halt_req_ff[0]) |-> $past(begin_ff[0]))
		else $error("halt accepted while begin clear");
	stop_clears_req_a: assert property (stop_det[0] |=> !halt_req_ff[0])
		else $error("halt_request not cleared by STOP");
	stop_clears_run_a: assert property (stop_det[0] |=> !halt_run_ff[0])
		else $error("halt_after_run not cleared by STOP");
	byte_halt_stop_a: assert property (halt_byte[0] |=> send_stop[0] && flush_seq[0] && !begin_ff[0])
		else $error("byte halt did not stop");
	halt_priority_a: assert property (state_ff[0] == i2c_seq_pkg::CH_RUN && halt_req_ff[0] && halt_run_ff[0]
		&& seq_done[0] && !byte_done[0] |=> !send_stop[0])
		else $error("sequence halt beat byte halt");
	single_end_a: assert property (end_one[0] |=> !begin_ff[0] ##1 !send_stop[0])
		else $error("begin not cleared at end");
	busy_fault_a: assert property (start_fail[0] |=> (dfault_ff[0] || cfault_ff[0]) ##1 !int_n)
		else $error("busy start not reported");
	free_start_a: assert property (send_start[0] |-> $past(!busy_ff[0] && scl_s[0] && sda_s[0]))
		else $error("START on busy bus");

	run_begins_c: cover property (start_ok[0] ##[1:50] end_one[0]);
	byte_halt_c: cover property (halt_byte[0] ##[1:50] stop_det[0]);
	busy_start_c: cover property (start_fail[0]);
endmodule : i2c_channel_sequence_control
`default_nettype wire

// [design/link_sync.sv]
// Two-stage synchroniser and START/STOP finder for the serial lines
`default_nettype none
module link_sync #(
	parameter int W = 3
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [W-1:0] scl_in,
	input wire logic [W-1:0] sda_in,
	output logic [W-1:0] scl_s,
	output logic [W-1:0] sda_s,
	output logic [W-1:0] start_det,
	output logic [W-1:0] stop_det
);
	logic [W-1:0] scl_m_ff; // First stage, read only by second
	logic [W-1:0] sda_m_ff;
	logic [W-1:0] scl_s_ff; // Synchronised levels
	logic [W-1:0] sda_s_ff;
	logic [W-1:0] scl_p_ff; // Previous synchronised levels
	logic [W-1:0] sda_p_ff;

	// Lines idle high, so reset to high avoids false conditions
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			scl_m_ff <= '1;
			sda_m_ff <= '1;
			scl_s_ff <= '1;
			sda_s_ff <= '1;
			scl_p_ff <= '1;
			sda_p_ff <= '1;
		end else begin
			scl_m_ff <= scl_in;
			sda_m_ff <= sda_in;
			scl_s_ff <= scl_m_ff;
			sda_s_ff <= sda_m_ff;
			scl_p_ff <= scl_s_ff;
			sda_p_ff <= sda_s_ff;
		end
	end

	assign scl_s = scl_s_ff;
	assign sda_s = sda_s_ff;
	// Data falls or rises while clock stays high
	assign start_det = scl_s_ff & scl_p_ff & ~sda_s_ff & sda_p_ff;
	assign stop_det = scl_s_ff & scl_p_ff & sda_s_ff & ~sda_p_ff;
endmodule : link_sync
`default_nettype wire

// [inc/i2c_seq_pkg.sv]
// Constants and types shared by the channel sequence control block
`default_nettype none
package i2c_seq_pkg;
	localparam int NCH = 3; // Number of serial channels
	localparam int ADDR_W = 8; // Register byte address width
	localparam logic [2:0] PP_CHANNELS = 3'b110; // Push-pull transmit-only channels
	localparam logic [7:0] CH_STRIDE = 8'h10; // Distance between channel register sets
	localparam logic [7:0] CTRL_OFS = 8'hC0; // Channel control, channel zero
	localparam logic [7:0] CFG_OFS = 8'hC4; // Repeat count and channel_on
	localparam logic [7:0] COND_OFS = 8'hC8; // Channel condition
	localparam int HALT_RUN_BIT = 7; // halt_after_run
	localparam int BEGIN_BIT = 6; // begin_flag
	localparam int HALT_REQ_BIT = 5; // halt_request
	localparam int CNT_W = 8; // repeat_count width
	localparam int CHON_BIT = 8; // channel_on in config word
	localparam int DATA_FAULT_BIT = 0; // data_line_fault
	localparam int CLK_FAULT_BIT = 1; // Clock line fault
	localparam int XFER_FAULT_BIT = 2; // Transfer error during run or stopping
	localparam int ACTIVE_BIT = 3; // Channel not idle
	localparam logic [CNT_W-1:0] CNT_RST = 8'h01; // repeat_count reset
	localparam logic [1:0] RESP_OKAY = 2'h0; // AXI OKAY
	localparam logic [1:0] RESP_SLVERR = 2'h2; // AXI SLVERR
	localparam logic [1:0] KIND_CTRL = 2'h0; // Decode kinds
	localparam logic [1:0] KIND_CFG = 2'h1;
	localparam logic [1:0] KIND_COND = 2'h2;
	typedef enum logic [1:0] {CH_IDLE, CH_RUN, CH_STOPPING} ch_state_t;
endpackage : i2c_seq_pkg
`default_nettype wire

// [verification/bus_partner.sv]
// Behavioural model of the serial lines as the far-side slaves see them
`default_nettype none
module bus_partner #(
	parameter int N = 3,
	parameter int HALF_NS = 32 // Half of the 64 ns link clock
) (
	input wire logic aclk,
	input wire logic [N-1:0] send_start,
	input wire logic [N-1:0] send_stop,
	input wire logic [N-1:0] hold_sda,
	input wire logic [N-1:0] hold_scl,
	output logic [N-1:0] scl_in,
	output logic [N-1:0] sda_in
);
	timeunit 1ns;
	timeprecision 1ps;
	for (genvar g = 0; g < N; g++) begin : g_line
		logic scl_q = 1'h1; // Pulled up while released
		logic sda_q = 1'h1;
		// A slave pulling data low makes the bus look busy
		assign sda_in[g] = sda_q & ~hold_sda[g];
		// A slave stretching the clock holds it low, with no START seen
		assign scl_in[g] = scl_q & ~hold_scl[g];
		// Clock stands still outside a frame, so only START and STOP move the lines
		always begin
			@(posedge aclk);
			if (send_start[g]) begin
				#2 sda_q = 1'h0;
				#HALF_NS scl_q = 1'h0;
			end else if (send_stop[g]) begin
				#2 sda_q = 1'h0;
				#HALF_NS scl_q = 1'h1;
				#HALF_NS sda_q = 1'h1;
			end
		end
	end
endmodule : bus_partner
`default_nettype wire

// [verification/i2c_channel_sequence_control_tb.sv]
// Register-level testbench for the channel sequence control block
`default_nettype none
module i2c_channel_sequence_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = 1'h0, aresetn = 1'h0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic [31:0] wdata = 32'h0, rdata, rd_v;
	logic [3:0] wstrb = 4'h0;
	logic awready, wready, bvalid, arready, rvalid, int_n;
	logic [1:0] bresp, rresp, rsp;
	logic [2:0] byte_done = 3'h0, seq_done = 3'h0, loop_done = 3'h0, reading = 3'h0, xfer_err = 3'h0;
	logic [2:0] hold_sda = 3'h0, scl_in, sda_in, send_start, send_stop, flush_seq, nack_last;
	logic [2:0] hold_scl = 3'h0; // Clock held low by a slave
	int n_s[3], n_p[3], n_f[3], b_s[3], b_p[3], b_f[3]; // Pulse counts and snapshots
	int err_total = 0, comparisons = 0, cycles = 0;
	i2c_channel_sequence_control i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.scl_in(scl_in), .sda_in(sda_in), .byte_done(byte_done), .seq_done(seq_done),
		.loop_done(loop_done), .reading(reading), .xfer_err(xfer_err), .send_start(send_start),
		.send_stop(send_stop), .flush_seq(flush_seq), .nack_last(nack_last), .int_n(int_n));
	bus_partner i_bus (.aclk(aclk), .send_start(send_start), .send_stop(send_stop), .hold_sda(hold_sda),
		.hold_scl(hold_scl), .scl_in(scl_in), .sda_in(sda_in));
	// Clock
	always #4 aclk = ~aclk;
	// Pulse counters and hang guard
	always @(posedge aclk) begin
		for (int c = 0; c < 3; c++) begin
			n_s[c] += int'(send_start[c] === 1'h1);
			n_p[c] += int'(send_stop[c] === 1'h1);
			n_f[c] += int'(flush_seq[c] === 1'h1);
		end
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			end_sim();
		end
	end
	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : end_sim
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
	endtask : tick
	// Write with both channels offered together, each released when taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		// Only the hang guard bounds this wait
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'h0;
			if (wvalid && wready) wvalid <= 1'h0;
		end while (!(bvalid === 1'h1 && bready));
		bready <= 1'h0;
		chk("bresp", {30'h0, bresp}, {30'h0, i2c_seq_pkg::RESP_OKAY});
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		// Only the hang guard bounds this wait
		do begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'h0;
		end while (rvalid !== 1'h1);
		rready <= 1'h0;
		rd_v = rdata;
		rsp = rresp;
	endtask : axi_rd
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
		axi_rd(a);
		chk(what, rd_v, exp);
	endtask : rd_chk
	// Engine pulse: 0 byte, 1 sequence, 2 loop, 3 transfer error
	task automatic pulse(input int k, input int ch);
		@(posedge aclk);
		case (k)
			0: byte_done <= 3'h1 << ch;
			1: seq_done <= 3'h1 << ch;
			2: loop_done <= 3'h1 << ch;
			default: xfer_err <= 3'h1 << ch;
		endcase
		@(posedge aclk);
		{byte_done, seq_done, loop_done, xfer_err} <= 12'h000;
		tick(3);
	endtask : pulse
	task automatic mark();
		b_s = n_s;
		b_p = n_p;
		b_f = n_f;
	endtask : mark
	task automatic cnt_chk(input int ch, input int s, input int p, input int f);
		chk("start pulses", 32'(n_s[ch] - b_s[ch]), 32'(s));
		chk("stop pulses", 32'(n_p[ch] - b_p[ch]), 32'(p));
		chk("flush pulses", 32'(n_f[ch] - b_f[ch]), 32'(f));
	endtask : cnt_chk
	// Poll until the channel reports idle, bounded
	task automatic wait_idle(input int ch);
		for (int i = 0; i < 40; i++) begin
			axi_rd(8'hC8 + 8'(ch * 16));
			if (rd_v[3] === 1'h0) break;
		end
		chk("active", {31'h0, rd_v[3]}, 32'h0);
	endtask : wait_idle
	// Main sequence
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'h1;
		tick(2);
		rd_chk(8'hC0, 32'h0, "ctrl reset");
		rd_chk(8'hC4, 32'h1, "cfg reset");
		axi_rd(8'hFC);
		chk("unmapped resp", {30'h0, rsp}, {30'h0, i2c_seq_pkg::RESP_SLVERR});
		mark();
		axi_wr(8'hC0, 32'h40);
		rd_chk(8'hC0, 32'h0, "begin while off");
		axi_wr(8'hC0, 32'hA0);
		rd_chk(8'hC0, 32'h0, "halt without begin");
		cnt_chk(0, 0, 0, 0);
		// Single run, count one
		axi_wr(8'hC4, 32'h101);
		axi_wr(8'hC0, 32'h40);
		tick(4);
		cnt_chk(0, 1, 0, 0);
		axi_wr(8'hC0, 32'h0);
		rd_chk(8'hC0, 32'h40, "zero write");
		pulse(1, 0);
		cnt_chk(0, 1, 1, 0);
		rd_chk(8'hC0, 32'h0, "begin after run");
		wait_idle(0);
		// Looping run, count three
		axi_wr(8'hC4, 32'h103);
		mark();
		axi_wr(8'hC0, 32'h40);
		pulse(1, 0);
		cnt_chk(0, 1, 0, 0);
		pulse(2, 0);
		cnt_chk(0, 1, 1, 0);
		rd_chk(8'hC0, 32'h0, "begin after loop");
		wait_idle(0);
		// Halt after run, endless count
		axi_wr(8'hC4, 32'h100);
		mark();
		axi_wr(8'hC0, 32'h40);
		axi_wr(8'hC0, 32'h80);
		rd_chk(8'hC0, 32'hC0, "halt run set");
		pulse(1, 0);
		cnt_chk(0, 1, 1, 1);
		wait_idle(0);
		rd_chk(8'hC0, 32'h0, "halt run cleared");
		// Both halts during a read, with an error before the final byte
		mark();
		axi_wr(8'hC0, 32'h40);
		reading <= 3'h1;
		axi_wr(8'hC0, 32'hA0);
		tick(3);
		chk("nack last", {31'h0, nack_last[0]}, 32'h1);
		pulse(3, 0);
		axi_rd(8'hC8);
		chk("error kept", {31'h0, rd_v[2]}, 32'h1);
		chk("int low", {31'h0, int_n}, 32'h0);
		// Sequence end with both halts pending must not stop yet
		pulse(1, 0);
		cnt_chk(0, 1, 0, 0);
		pulse(0, 0);
		cnt_chk(0, 1, 1, 1);
		rd_chk(8'hC0, 32'hA0, "begin after byte halt");
		reading <= 3'h0;
		wait_idle(0);
		rd_chk(8'hC0, 32'h0, "halt req cleared");
		axi_wr(8'hC8, 32'h4);
		tick(3);
		chk("int released", {31'h0, int_n}, 32'h1);
		// Start on a busy bus
		hold_sda <= 3'h1;
		tick(8);
		mark();
		axi_wr(8'hC0, 32'h40);
		tick(4);
		cnt_chk(0, 0, 0, 0);
		rd_chk(8'hC8, 32'h1, "busy fault");
		chk("busy int", {31'h0, int_n}, 32'h0);
		rd_chk(8'hC0, 32'h0, "begin refused");
		hold_sda <= 3'h0;
		tick(8);
		axi_wr(8'hC8, 32'h1);
		tick(3);
		chk("fault cleared", {31'h0, int_n}, 32'h1);
		// Clock held low with data high blames the clock line
		hold_scl <= 3'h1;
		tick(8);
		mark();
		axi_wr(8'hC0, 32'h40);
		tick(4);
		cnt_chk(0, 0, 0, 0);
		rd_chk(8'hC8, 32'h2, "clock fault");
		chk("clock fault int", {31'h0, int_n}, 32'h0);
		rd_chk(8'hC0, 32'h0, "begin refused clock");
		hold_scl <= 3'h0;
		tick(8);
		axi_wr(8'hC8, 32'h2);
		tick(3);
		chk("clock fault cleared", {31'h0, int_n}, 32'h1);
		// Second channel at its own address
		axi_wr(8'hD4, 32'h101);
		// Push-pull channel starts even with its data line held low
		hold_sda <= 3'h2;
		tick(8);
		mark();
		axi_wr(8'hD0, 32'h40);
		tick(4);
		cnt_chk(1, 1, 0, 0);
		hold_sda <= 3'h0;
		rd_chk(8'hD0, 32'h40, "ch1 ctrl");
		rd_chk(8'hC0, 32'h0, "ch0 untouched");
		rd_chk(8'hD8, 32'h8, "ch1 no fault");
		pulse(1, 1);
		wait_idle(1);
		end_sim();
	end
endmodule : i2c_channel_sequence_control_tb
`default_nettype wire
